// ===== rtl/brbc_bound.sv
// Purpose: aligned boundary detection for one dword address
// Assumes: line size in dwords, as programmed
// Notes: purely combinational, one copy per address stream
`timescale 1ns/1ps
`default_nettype none
module brbc_bound
  import brbc_pkg::*;
(
  // address and line size
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] ls,
  // results
  output logic ls_ok,
  output logic ls_small,
  output logic end_line,
  output logic end_16,
  output logic end_4k
);
  logic [7:0] mask;

  // line size check and boundary compares
  always_comb begin
    mask = ls - 8'h01;
    ls_ok = (ls != 8'h00) && ((ls & mask) == 8'h00) && (ls <= LS_MAX);
    ls_small = ls_ok && (ls != LS_MAX);
    end_line = ((addr[7:0] & mask) == mask);
    end_16 = &addr[3:0];
    end_4k = &addr[9:0];
  end
endmodule
`default_nettype wire

// ===== rtl/brbc_ctrl.sv
// Purpose: write disconnect and read prefetch policy of a pci bridge
// Assumes: all inputs come from logic on SYS_CLK
// Notes: answers appear one clock after the request is taken
`timescale 1ns/1ps
`default_nettype none
module brbc_ctrl
  import brbc_pkg::*;
(
  // clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  // configuration access
  input wire logic [7:0] CFG_ADDR,
  input wire logic CFG_WE,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  // enables and queue state from elsewhere
  input wire logic CMD_FB2B_EN,
  input wire logic BRC_FB2B_EN,
  input wire logic DQ_FULL,
  // write requests from the initiator bus
  input wire logic W_START,
  input wire logic [3:0] W_CMD,
  input wire logic [ADDR_W-1:0] W_ADDR,
  input wire logic W_UP,
  input wire logic W_FAST,
  input wire logic W_VALID,
  input wire logic [31:0] W_DATA,
  input wire logic [3:0] W_BE,
  input wire logic W_LAST,
  // write answers
  output logic W_RETRY,
  output logic W_ACK,
  output logic W_DISC,
  output logic DW_QUEUE,
  // posted data toward the target bus
  output logic PO_VALID,
  output logic [31:0] PO_DATA,
  output logic [3:0] PO_BE,
  output logic PO_FIRST,
  output logic PO_FB2B,
  input wire logic PO_READY,
  // read requests and target progress
  input wire logic R_START,
  input wire logic [3:0] R_CMD,
  input wire logic [ADDR_W-1:0] R_ADDR,
  input wire logic [3:0] R_BE,
  input wire logic R_UP,
  input wire logic R_PREF_SPACE,
  input wire logic RT_VALID,
  input wire logic RT_DISC,
  input wire logic RQ_FULL,
  input wire logic FT_MODE,
  input wire logic I_FRAME_END,
  input wire logic RD_EMPTY,
  // read answers
  output logic RT_PREF,
  output logic [3:0] RT_BE,
  output logic RT_STOP,
  output logic RI_DISC,
  output logic RD_DISCARD
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] line_size_value;
    logic [7:0] rdata;
    brbc_wst_t wst;
    brbc_wmode_t wmode;
    logic [ADDR_W-1:0] waddr;
    logic wfirst;
    logic wfb2b;
    logic [5:0] used;
    logic [4:0] wp;
    logic [4:0] rp;
    logic w_retry;
    logic w_ack;
    logic w_disc;
    logic dw_q;
    brbc_rst_t rst;
    brbc_rmode_t rmode;
    logic [ADDR_W-1:0] raddr;
    logic rlines;
    logic rt_pref;
    logic [3:0] rt_be;
    logic rt_stop;
    logic ri_disc;
    logic rd_discard;
  } brbc_st_t;
  brbc_st_t s_reg;
  brbc_st_t s_next;

  logic w_ls_ok;
  logic w_ls_small;
  logic w_end_line;
  logic w_end_16;
  logic w_end_4k;
  logic r_ls_ok;
  logic r_ls_small;
  logic r_end_line;
  logic r_end_16;
  logic r_end_4k;
  logic push;
  logic pop;
  logic fin_ready;
  logic po_valid;
  logic [FIFO_W-1:0] po_word;
  logic [5:0] free;
  logic [5:0] free_after;
  logic wstop;
  logic pref;
  logic rhit;
  // posted write data buffer, one word per accepted dword
  logic [FIFO_W-1:0] pw_mem [32];

  // boundary checks on the running write and read addresses
  brbc_bound u_wb (
    .addr(s_reg.waddr),
    .ls(s_reg.line_size_value),
    .ls_ok(w_ls_ok),
    .ls_small(w_ls_small),
    .end_line(w_end_line),
    .end_16(w_end_16),
    .end_4k(w_end_4k)
  );
  brbc_bound u_rb (
    .addr(s_reg.raddr),
    .ls(s_reg.line_size_value),
    .ls_ok(r_ls_ok),
    .ls_small(r_ls_small),
    .end_line(r_end_line),
    .end_16(r_end_16),
    .end_4k(r_end_4k)
  );

  // output stage fed from the posted buffer, a target stall backs up the buffer
  brbc_fifo2 #(
    .W(FIFO_W)
  ) u_po (
    .clk(SYS_CLK),
    .rst(RST),
    .ce(CE),
    .in_valid(pop),
    .in_data(pw_mem[s_reg.rp]),
    .in_ready(fin_ready),
    .out_valid(po_valid),
    .out_data(po_word),
    .out_ready(PO_READY)
  );

  // next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.w_retry = 1'b0;
    s_next.w_ack = 1'b0;
    s_next.w_disc = 1'b0;
    s_next.dw_q = 1'b0;
    s_next.rd_discard = 1'b0;
    pop = (s_reg.used != 6'h00) && fin_ready;
    free = PW_DEPTH - s_reg.used;
    free_after = free - 6'h01;
    push = 1'b0;
    wstop = 1'b0;
    pref = 1'b0;
    rhit = 1'b0;

    // configuration writes
    if (CFG_WE && CFG_ADDR == OFS_CHIP_CTRL) begin
      s_next.ctrl = CFG_WDATA;
    end
    if (CFG_WE && CFG_ADDR == OFS_CLS) begin
      s_next.line_size_value = CFG_WDATA;
    end
    // configuration reads, status shows buffer use and busy states
    case (CFG_ADDR)
      OFS_CHIP_CTRL: s_next.rdata = s_reg.ctrl;
      OFS_CLS: s_next.rdata = s_reg.line_size_value;
      OFS_STATUS: s_next.rdata = {s_reg.rst != R_IDLE, s_reg.wst != W_IDLE, s_reg.used};
      default: s_next.rdata = 8'h00;
    endcase

    // write side
    case (s_reg.wst)
      W_IDLE: begin
        if (W_START && (W_CMD == CMD_IO_WR || W_CMD == CMD_CFG_WR)) begin
          if (DQ_FULL) begin
            s_next.w_retry = 1'b1;
          end else begin
            s_next.wst = W_DEL;
          end
        end else if (W_START && (W_CMD == CMD_MEM_WR || W_CMD == CMD_MWI)) begin
          if (free == 6'h00 || (W_FAST && !fin_ready)) begin
            s_next.w_retry = 1'b1;
          end else begin
            s_next.wst = W_POST;
            s_next.waddr = W_ADDR;
            s_next.wfirst = 1'b1;
            s_next.wfb2b = W_UP ? CMD_FB2B_EN : BRC_FB2B_EN;
            if (W_CMD == CMD_MWI && w_ls_ok) begin
              s_next.wmode = w_ls_small ? WM_MWI : WM_16;
            end else if (s_reg.ctrl[BIT_MW_DISC] && w_ls_ok) begin
              s_next.wmode = WM_LINE;
            end else begin
              s_next.wmode = WM_4K;
            end
          end
        end
      end
      W_DEL: begin
        if (W_VALID && !s_reg.w_ack) begin
          s_next.w_ack = 1'b1;
          s_next.w_disc = 1'b1;
          s_next.dw_q = 1'b1;
          s_next.wst = W_IDLE;
        end
      end
      W_POST: begin
        if (W_VALID && !s_reg.w_ack && free != 6'h00) begin
          push = 1'b1;
          s_next.w_ack = 1'b1;
          s_next.wfirst = 1'b0;
          s_next.waddr = s_reg.waddr + 30'h1;
          case (s_reg.wmode)
            WM_LINE: wstop = w_end_line;
            WM_16: wstop = w_end_16;
            WM_MWI: wstop = w_end_line && (free_after < MWI_MIN_FREE);
            default: wstop = w_end_4k;
          endcase
          if (free_after == 6'h00) begin
            wstop = 1'b1;
          end
          s_next.w_disc = wstop && !W_LAST;
          if (wstop || W_LAST) begin
            s_next.wst = W_IDLE;
          end
        end
      end
      default: s_next.wst = W_IDLE;
    endcase
    s_next.used = s_reg.used + {5'h00, push} - {5'h00, pop};
    if (push) begin
      s_next.wp = s_reg.wp + 5'h01;
    end
    if (pop) begin
      s_next.rp = s_reg.rp + 5'h01;
    end

    // read side
    case (s_reg.rst)
      R_IDLE: begin
        if (R_START) begin
          if (R_CMD == CMD_MRL || R_CMD == CMD_MRM) begin
            pref = 1'b1;
          end else if (R_CMD == CMD_MEM_RD) begin
            pref = R_UP ? !s_reg.ctrl[BIT_PF_DIS] : R_PREF_SPACE;
          end
          s_next.rt_pref = pref;
          s_next.rt_be = pref ? BE_ALL : R_BE;
          if (!pref) begin
            s_next.rmode = RM_ONE;
          end else if (R_CMD == CMD_MRM) begin
            s_next.rmode = r_ls_small ? RM_2ND : RM_FULL;
          end else begin
            s_next.rmode = r_ls_small ? RM_LINE : RM_16;
          end
          s_next.raddr = R_ADDR;
          s_next.rlines = 1'b0;
          s_next.rt_stop = 1'b0;
          s_next.ri_disc = 1'b0;
          s_next.rst = R_FETCH;
        end
      end
      R_FETCH: begin
        if (RT_VALID) begin
          s_next.raddr = s_reg.raddr + 30'h1;
          if (r_end_line) begin
            s_next.rlines = 1'b1;
          end
          if (FT_MODE && s_reg.rmode != RM_ONE) begin
            rhit = r_end_4k;
          end else begin
            case (s_reg.rmode)
              RM_LINE: rhit = r_end_line;
              RM_16: rhit = r_end_16;
              RM_2ND: rhit = r_end_line && s_reg.rlines;
              RM_FULL: rhit = 1'b0;
              default: rhit = 1'b1;
            endcase
          end
        end
        if (FT_MODE && I_FRAME_END) begin
          rhit = 1'b1;
        end
        if (RQ_FULL || RT_DISC) begin
          rhit = 1'b1;
        end
        if (rhit) begin
          s_next.rt_stop = 1'b1;
          s_next.ri_disc = 1'b1;
          s_next.rst = R_DONE;
        end
      end
      R_DONE: begin
        if (I_FRAME_END) begin
          s_next.rd_discard = !RD_EMPTY;
          s_next.rt_stop = 1'b0;
          s_next.ri_disc = 1'b0;
          s_next.rt_pref = 1'b0;
          s_next.rst = R_IDLE;
        end
      end
      default: s_next.rst = R_IDLE;
    endcase
  end

  // state register, frozen while CE is low
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s_reg <= '0;
      s_reg.ctrl <= CHIP_CTRL_RST;
      s_reg.line_size_value <= CLS_RST;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  // buffer write, frozen with the rest of the state
  always_ff @(posedge SYS_CLK) begin
    if (CE && push) begin
      pw_mem[s_reg.wp] <= {W_DATA, W_BE, s_reg.wfirst, s_reg.wfb2b};
    end
  end

  // outputs straight from state
  assign CFG_RDATA = s_reg.rdata;
  assign W_RETRY = s_reg.w_retry;
  assign W_ACK = s_reg.w_ack;
  assign W_DISC = s_reg.w_disc;
  assign DW_QUEUE = s_reg.dw_q;
  assign PO_VALID = po_valid;
  assign PO_DATA = po_word[37:6];
  assign PO_BE = po_word[5:2];
  assign PO_FIRST = po_word[1];
  assign PO_FB2B = po_word[0];
  assign RT_PREF = s_reg.rt_pref;
  assign RT_BE = s_reg.rt_be;
  assign RT_STOP = s_reg.rt_stop;
  assign RI_DISC = s_reg.ri_disc;
  assign RD_DISCARD = s_reg.rd_discard;
endmodule
`default_nettype wire

// ===== rtl/brbc_fifo2.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: head always in entry 0
// Notes: outputs come from flip-flops
`timescale 1ns/1ps
`default_nettype none
module brbc_fifo2 #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic v0;
    logic v1;
  } brbc_fifo_st_t;
  brbc_fifo_st_t s_reg;
  brbc_fifo_st_t s_next;

  // pop shifts entry 1 down, push fills the first free entry
  always_comb begin
    s_next = s_reg;
    if (s_reg.v0 && out_ready) begin
      s_next.mem[0] = s_reg.mem[1];
      s_next.v0 = s_reg.v1;
      s_next.v1 = 1'b0;
    end
    if (in_valid && !s_reg.v1) begin
      if (s_next.v0) begin
        s_next.mem[1] = in_data;
        s_next.v1 = 1'b1;
      end else begin
        s_next.mem[0] = in_data;
        s_next.v0 = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign in_ready = !s_reg.v1;
  assign out_valid = s_reg.v0;
  assign out_data = s_reg.mem[0];
endmodule
`default_nettype wire

// ===== rtl/brbc_pkg.sv
// Purpose: constants and types shared by the burst boundary control block
// Assumes: dword addresses, pci command encodings, one clock domain
// Notes: offsets are configuration-space byte offsets
package brbc_pkg;
  // bus commands
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [3:0] CMD_MRM = 4'hc;
  localparam logic [3:0] CMD_MRL = 4'he;
  localparam logic [3:0] CMD_MWI = 4'hf;
  // configuration offsets
  localparam logic [7:0] OFS_CLS = 8'h0c;
  localparam logic [7:0] OFS_CHIP_CTRL = 8'h40;
  localparam logic [7:0] OFS_STATUS = 8'h44;
  // field positions in bridge_chip_control
  localparam int BIT_MW_DISC = 1;
  localparam int BIT_PF_DIS = 2;
  // values after reset
  localparam logic [7:0] CHIP_CTRL_RST = 8'h00;
  localparam logic [7:0] CLS_RST = 8'h00;
  // widths and counts
  localparam int ADDR_W = 30;
  localparam int FIFO_W = 38;
  localparam logic [5:0] PW_DEPTH = 6'h20;
  localparam logic [5:0] MWI_MIN_FREE = 6'h08;
  localparam logic [7:0] LS_MAX = 8'h10;
  localparam logic [3:0] BE_ALL = 4'hf;
  // state encodings
  typedef enum logic [1:0] {W_IDLE, W_POST, W_DEL} brbc_wst_t;
  typedef enum logic [1:0] {WM_4K, WM_LINE, WM_16, WM_MWI} brbc_wmode_t;
  typedef enum logic [1:0] {R_IDLE, R_FETCH, R_DONE} brbc_rst_t;
  typedef enum logic [2:0] {RM_ONE, RM_LINE, RM_16, RM_2ND, RM_FULL} brbc_rmode_t;
endpackage

// ===== tb/brbc_ctrl_assertions.sv
// Purpose: port checks for brbc_ctrl
// Assumes: CE held high by the bench
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module brbc_ctrl_assertions
  import brbc_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // write side
  input wire logic W_START,
  input wire logic [3:0] W_CMD,
  input wire logic DQ_FULL,
  input wire logic W_RETRY,
  input wire logic W_ACK,
  input wire logic W_DISC,
  input wire logic DW_QUEUE,
  // read side
  input wire logic R_START,
  input wire logic [3:0] R_CMD,
  input wire logic [3:0] R_BE,
  input wire logic RT_PREF,
  input wire logic [3:0] RT_BE,
  input wire logic RT_VALID,
  input wire logic RT_DISC,
  input wire logic RT_STOP,
  input wire logic RI_DISC,
  input wire logic I_FRAME_END,
  input wire logic RD_EMPTY,
  input wire logic RD_DISCARD
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // write answers
  a_disc_with_ack: assert property (W_DISC |-> W_ACK) else $error("disc no ack");
  a_delayed_one: assert property (DW_QUEUE |-> W_ACK && W_DISC) else $error("dw");
  a_dq_retry: assert property (W_START && W_CMD == CMD_IO_WR
    |=> W_RETRY == $past(DQ_FULL)) else $error("delayed retry");
  // read setup
  a_nonpref_be: assert property (R_START && (R_CMD == CMD_IO_RD || R_CMD == CMD_CFG_RD)
    |=> !RT_PREF && RT_BE == $past(R_BE)) else $error("nonpref be");
  a_pref_be: assert property (RT_PREF |-> RT_BE == BE_ALL) else $error("pref be");
  a_line_pref: assert property (R_START && (R_CMD == CMD_MRL || R_CMD == CMD_MRM)
    |=> RT_PREF) else $error("line read");
  // read stop and end
  a_one_dword: assert property (RT_VALID && !RT_PREF |=> RT_STOP && RI_DISC)
    else $error("single dword");
  a_target_disc: assert property (RT_DISC && !RT_STOP |=> RT_STOP && RI_DISC)
    else $error("target disc");
  a_stop_hold: assert property (RT_STOP && !I_FRAME_END |=> RT_STOP) else $error("stop");
  a_end_discard: assert property (RT_STOP && I_FRAME_END
    |=> !RT_STOP && RD_DISCARD == $past(!RD_EMPTY)) else $error("discard");
  // main scenarios
  c_wdisc: cover property (W_DISC);
  c_retry: cover property (W_RETRY);
  c_discard: cover property (RD_DISCARD);
endmodule
bind brbc_ctrl brbc_ctrl_assertions u_chk (.SYS_CLK, .RST, .W_START, .W_CMD, .DQ_FULL,
  .W_RETRY, .W_ACK, .W_DISC, .DW_QUEUE, .R_START, .R_CMD, .R_BE, .RT_PREF, .RT_BE,
  .RT_VALID, .RT_DISC, .RT_STOP, .RI_DISC, .I_FRAME_END, .RD_EMPTY, .RD_DISCARD);
`default_nettype wire

// ===== tb/brbc_ctrl_test.sv
// Purpose: self-checking bench for brbc_ctrl
// Assumes: CE held high, inputs driven 1 ns after the edge
// Notes: write and read cases run from tables
`timescale 1ns/1ps
`default_nettype none
module brbc_ctrl_test
  import brbc_pkg::*;
;
  logic SYS_CLK = 0, RST = 1, CE = 1, CFG_WE = 0, CMD_FB2B_EN = 0, BRC_FB2B_EN = 0;
  logic DQ_FULL = 0, W_START = 0, W_UP = 0, W_FAST = 0, W_VALID = 0, W_LAST = 0;
  logic R_START = 0, R_UP = 0, R_PREF_SPACE = 0, FT_MODE = 0, I_FRAME_END = 0, RD_EMPTY = 1;
  logic [7:0] CFG_ADDR = '0, CFG_WDATA = '0, CFG_RDATA;
  logic [3:0] W_CMD = '0, W_BE = '1, R_CMD = '0, R_BE = 4'h5, PO_BE, RT_BE;
  logic [ADDR_W-1:0] W_ADDR = '0, R_ADDR = '0;
  logic [31:0] W_DATA = '0, PO_DATA;
  logic W_RETRY, W_ACK, W_DISC, DW_QUEUE, PO_VALID, PO_FIRST, PO_FB2B, PO_READY;
  logic RT_VALID, RT_DISC, RQ_FULL, RT_PREF, RT_STOP, RI_DISC, RD_DISCARD, rty;
  logic stall = 0, go = 0;
  logic [5:0] disc_at = '0;
  int error_cnt = 0, checked = 0, words, firsts, fb2b_cnt, rcnt, idx, ew = 0, ef = 0;
  // cmd addr ctrl ls n disc_index fast
  int wt[7][7] = '{'{3, 5, 0, 0, 4, 1, 0}, '{7, 'h3fc, 0, 0, 8, 4, 0}, '{7, 5, 2, 8, 8, 3, 1},
    '{'hf, 0, 0, 16, 20, 16, 0}, '{'hf, 'h3fe, 0, 3, 4, 2, 0}, '{7, 'h3fd, 2, 3, 5, 3, 0},
    '{'hf, 0, 0, 4, 12, 0, 0}};
  // cmd addr ctrl ls up space ft disc pref count
  int rt[12][10] = '{'{2, 5, 0, 0, 0, 0, 0, 0, 0, 1}, '{'ha, 6, 0, 0, 0, 0, 0, 0, 0, 1},
    '{6, 7, 0, 0, 0, 0, 0, 0, 0, 1}, '{6, 3, 0, 0, 0, 1, 0, 0, 1, 13},
    '{6, 2, 0, 8, 1, 0, 0, 0, 1, 6}, '{6, 2, 4, 8, 1, 0, 0, 0, 0, 1},
    '{'he, 1, 0, 4, 0, 0, 0, 0, 1, 3}, '{'hc, 1, 0, 4, 0, 0, 0, 0, 1, 7},
    '{'he, 'h10, 0, 16, 0, 0, 0, 0, 1, 16}, '{'hc, 0, 0, 0, 0, 0, 0, 0, 1, 24},
    '{6, 'h3fa, 0, 16, 0, 1, 1, 0, 1, 6}, '{'he, 0, 0, 16, 0, 0, 0, 3, 1, 3}};
  always #5 SYS_CLK = ~SYS_CLK;
  brbc_ctrl dut (.SYS_CLK, .RST, .CE, .CFG_ADDR, .CFG_WE, .CFG_WDATA, .CFG_RDATA,
    .CMD_FB2B_EN, .BRC_FB2B_EN, .DQ_FULL, .W_START, .W_CMD, .W_ADDR, .W_UP, .W_FAST,
    .W_VALID, .W_DATA, .W_BE, .W_LAST, .W_RETRY, .W_ACK, .W_DISC, .DW_QUEUE, .PO_VALID,
    .PO_DATA, .PO_BE, .PO_FIRST, .PO_FB2B, .PO_READY, .R_START, .R_CMD, .R_ADDR, .R_BE,
    .R_UP, .R_PREF_SPACE, .RT_VALID, .RT_DISC, .RQ_FULL, .FT_MODE, .I_FRAME_END, .RD_EMPTY,
    .RT_PREF, .RT_BE, .RT_STOP, .RI_DISC, .RD_DISCARD);
  brbc_tgt_model #(.QF(24)) u_tgt (.clk(SYS_CLK), .rst(RST), .po_valid(PO_VALID),
    .po_first(PO_FIRST), .po_fb2b(PO_FB2B), .stall(stall), .po_ready(PO_READY), .go(go),
    .rt_stop(RT_STOP), .disc_at(disc_at), .rt_valid(RT_VALID), .rt_disc(RT_DISC),
    .rq_full(RQ_FULL), .words(words), .firsts(firsts), .fb2b_cnt(fb2b_cnt), .rcnt(rcnt));
  // shared steps
  task automatic tick;
    @(posedge SYS_CLK);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    CFG_ADDR = a;
    CFG_WDATA = d;
    CFG_WE = 1;
    tick;
    CFG_WE = 0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    CFG_ADDR = a;
    tick;
    chk("cfg", e, CFG_RDATA);
  endtask
  task automatic wr(input int c, input int a, input int f, input int n);
    int t;
    W_START = 1;
    W_CMD = c;
    W_ADDR = a;
    W_FAST = f;
    tick;
    W_START = 0;
    idx = 0;
    rty = W_RETRY;
    for (int i = 0; i < n && rty !== 1'b1 && idx == 0; i++) begin
      W_VALID = 1;
      W_LAST = i == n - 1;
      W_DATA = a + i;
      t = 0;
      do begin
        tick;
        t++;
      end while (W_ACK !== 1'b1 && t < 60);
      if (W_ACK !== 1'b1) chk("ack", 1, W_ACK);
      if (W_DISC === 1'b1) idx = i + 1;
    end
    W_VALID = 0;
    W_LAST = 0;
  endtask
  task automatic drain;
    int t = 0;
    while (PO_VALID === 1'b1 && t < 100) begin
      tick;
      t++;
    end
    repeat (3) tick;
  endtask
  task automatic rd(input int k);
    int t = 0;
    cfg(OFS_CHIP_CTRL, rt[k][2]);
    cfg(OFS_CLS, rt[k][3]);
    R_START = 1;
    R_CMD = rt[k][0];
    R_ADDR = rt[k][1];
    R_UP = rt[k][4];
    R_PREF_SPACE = rt[k][5];
    FT_MODE = rt[k][6];
    disc_at = rt[k][7];
    tick;
    R_START = 0;
    go = 1;
    chk("pref", rt[k][8], RT_PREF);
    chk("be", rt[k][8] ? 4'hf : 4'h5, RT_BE);
    while (RT_STOP !== 1'b1 && t < 200) begin
      tick;
      t++;
    end
    chk("rcnt", rt[k][9], rcnt);
    chk("idisc", 1, RI_DISC);
    RD_EMPTY = k[0];
    I_FRAME_END = 1;
    tick;
    I_FRAME_END = 0;
    go = 0;
    chk("discard", !k[0], RD_DISCARD);
    RD_EMPTY = 1;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #300000;
    error_cnt++;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge SYS_CLK);
    #1;
    RST = 0;
    for (int k = 0; k < 7; k++) begin
      cfg(OFS_CHIP_CTRL, wt[k][2]);
      cfg(OFS_CLS, wt[k][3]);
      wr(wt[k][0], wt[k][1], wt[k][6], wt[k][4]);
      chk("retry", 0, rty);
      chk("disc", wt[k][5], idx);
      ew += wt[k][0] == 3 ? 0 : (idx != 0 ? idx : wt[k][4]);
      ef += wt[k][0] != 3;
      drain;
      chk("words", ew, words);
      chk("firsts", ef, firsts);
    end
    for (int k = 0; k < 12; k++) rd(k);
    // full buffer, retries and delayed beside posted data
    CMD_FB2B_EN = 1;
    cfg(OFS_CHIP_CTRL, 8'h00);
    cfg(OFS_CLS, 8'h00);
    stall = 1;
    wr(7, 0, 0, 60);
    chk("full", 1, idx >= 32 && idx <= 34);
    ew += idx;
    wr(7, 'h80, 1, 2);
    chk("fastretry", 1, rty);
    DQ_FULL = 1;
    wr(3, 5, 0, 1);
    chk("dqretry", 1, rty);
    DQ_FULL = 0;
    wr(3, 6, 0, 4);
    chk("dwtaken", 1, idx);
    stall = 0;
    drain;
    chk("words", ew, words);
    // small-line invalidate write under a stalled target
    cfg(OFS_CLS, 8'h04);
    stall = 1;
    wr('hf, 0, 0, 60);
    chk("mwi", 1, idx % 4 == 0 && idx >= 24 && idx <= 36);
    stall = 0;
    drain;
    chk("fb2b", 0, fb2b_cnt);
    // register access and a second reset
    cfg(OFS_CHIP_CTRL, 8'h06);
    rchk(OFS_CHIP_CTRL, 8'h06);
    cfg(8'h55, 8'h5a);
    rchk(8'h55, 8'h00);
    RST = 1;
    tick;
    RST = 0;
    rchk(OFS_CHIP_CTRL, CHIP_CTRL_RST);
    rchk(OFS_CLS, CLS_RST);
    end_of_test;
  end
endmodule
`default_nettype wire

// ===== tb/brbc_tgt_model.sv
// Purpose: far-side target model for brbc_ctrl
// Assumes: one word per accepted beat
// Notes: read dwords paced one every third cycle
`timescale 1ns/1ps
`default_nettype none
module brbc_tgt_model #(
  parameter int QF = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // posted stream
  input wire logic po_valid,
  input wire logic po_first,
  input wire logic po_fb2b,
  input wire logic stall,
  output logic po_ready,
  // read fetch
  input wire logic go,
  input wire logic rt_stop,
  input wire logic [5:0] disc_at,
  output logic rt_valid,
  output logic rt_disc,
  output logic rq_full,
  // counts
  output int words,
  output int firsts,
  output int fb2b_cnt,
  output int rcnt
);
  int ph;
  assign po_ready = !stall;
  assign rq_full = rcnt >= QF;
  // accepted posted words
  always @(posedge clk) begin
    if (rst) begin
      words <= 0;
      firsts <= 0;
      fb2b_cnt <= 0;
    end else if (po_valid && po_ready) begin
      words <= words + 1;
      firsts <= firsts + po_first;
      fb2b_cnt <= fb2b_cnt + po_fb2b;
    end
  end
  // read dwords until told to stop
  always @(posedge clk) begin
    rt_valid <= 0;
    rt_disc <= 0;
    if (rst || !go) begin
      ph <= 0;
      rcnt <= 0;
    end else if (!rt_stop) begin
      ph <= ph == 2 ? 0 : ph + 1;
      if (ph == 2 && disc_at != 0 && rcnt == disc_at) rt_disc <= 1;
      else if (ph == 2) rt_valid <= 1;
      if (ph == 2 && !(disc_at != 0 && rcnt == disc_at)) rcnt <= rcnt + 1;
    end
  end
endmodule
`default_nettype wire
